/* rtl/mifd_core.sv */
// instruction format decoder and sequencer: takes fetched 14-bit words,
// runs each through a four-phase cycle, does read-modify-write on the
// register file and keeps the accumulator and program counter.
// assumes the fetch path presents instr_word for the address on
// program_counter within the clock in which it changes, and the file read data
// answer in the same clock as file_rd_en.
//
// Overview of operation
// [RQ1] every instruction is one 14-bit word
// [RQ2] three classes: byte, bit, literal/control
// [RQ3] target bit zero goes to accumulator
// [RQ4] tools default the target bit to one
// [RQ5] register selector spans 0x00 to 0x7f
// [RQ6] position field picks one bit of eight
// [RQ7] constant is eight or eleven bits
// [RQ8] four oscillator phases make one cycle
// [RQ9] skip or jump costs a second idle cycle
// [RQ10] don't-care bits are ignored, tools emit zero
// [RQ11] file operands are read, modified, stored
// [RQ12] pure writes still read the register
// [RQ13] rmw on second port counts as read
// [RQ14] software avoids legacy configuration instructions
// [RQ15] one accumulator, implicit operand and target
// [RQ16] prefetched word dropped on change or skip
// [RQ17] unknown encodings execute as idle cycle
`timescale 1ns/1ns
module mifd_core #(
   parameter int PC_W      = 13,   // program counter width
   parameter int STACK_DEP = 8     // return stack depth
) (
   input  wire logic          clock,
   input  wire logic          rst,
   input  wire logic [13:0]   instr_word,        // fetched word
   output logic [12:0]        program_counter,   // fetch address
   output logic               fetch_en,          // latch new word (phase 3)
   output logic               file_rd_en,        // file read strobe
   output logic               file_wr_en,        // file write strobe
   output logic [6:0]         file_addr,         // selected file register
   input  wire logic [7:0]    file_rd_data,
   output logic [7:0]         file_wr_data,
   output logic               port_change_rearm, // second_io_port read seen
   output logic [7:0]         accumulator,
   output logic [1:0]         phase,
   output logic               idle_cycle         // idle second cycle after reset, a change or a skip
);

   ////////////////////////////////////////////////////////////////////////
   // elaboration checks
   initial begin
      if (PC_W != 13) $error("mifd_core: PC_W must be 13");
      if (STACK_DEP < 1 || STACK_DEP > 16) $error("mifd_core: STACK_DEP out of range");
   end

   ////////////////////////////////////////////////////////////////////////
   // all state except the return stack in one struct
   typedef struct packed {
      logic [1:0]  phase;      // oscillator period within cycle
      logic [13:0] instr;      // word being executed
      logic        flush;      // set in phase 2 of a change or skip, cleared in phase 2 of the idle cycle
      logic [7:0]  acc;        // working accumulator
      logic [12:0] pc;         // program counter
      logic [7:0]  opnd;       // value read in phase 1
      logic [3:0]  sp;         // return stack pointer
      logic [7:0]  wr_data;    // store data
      logic        wr_en;      // store strobe
      logic        rd_en;      // read strobe
      logic        rearm;      // port read pulse
      logic        idle;       // idle second cycle, phases 0..3
   } mifd_state_t;

   mifd_state_t st_reg;                        // registered state
   mifd_state_t st_next;                       // next state
   logic [12:0] stack_reg [STACK_DEP];         // return addresses

   mifd_pkg::mifd_class_t cls;                 // decoded class
   mifd_pkg::mifd_op_t    op;                  // decoded operation
   logic                  dest_file;           // result target bit
   logic [6:0]            faddr;               // register selector
   logic [2:0]            bit_sel;             // bit position
   logic [7:0]            lit8;                // short constant
   logic [10:0]           lit11;               // long constant

   ////////////////////////////////////////////////////////////////////////
   // field split of the word in execution
   mifd_field_split u_split (
      .instr       (st_reg.instr),             // [RQ1]
      .instr_class (cls),
      .op          (op),
      .dest_file   (dest_file),
      .faddr       (faddr),
      .bit_sel     (bit_sel),
      .lit8        (lit8),
      .lit11       (lit11)
   );

   ////////////////////////////////////////////////////////////////////////
   // next-state logic; phase 0 read, 2 modify/store, 3 fetch
   logic [7:0]  res;        // modified value
   logic        skip;       // conditional test true
   logic        to_file;    // result goes back to file
   logic        uses_file;  // byte or bit class touches a file register
   logic [7:0]  mask;       // one-hot bit mask
   logic [8:0]  sum;        // adder result
   always_comb begin
      st_next = st_reg;
      res = st_reg.opnd;
      skip = 1'b0;
      to_file = 1'b0;
      mask = 8'h01 << bit_sel;                                            // [RQ6]
      sum = 9'h000;
      uses_file = !st_reg.flush && (cls != mifd_pkg::MIFD_CLS_LIT) &&
                  op != mifd_pkg::MIFD_OP_IDLE && op != mifd_pkg::MIFD_OP_CLRW &&
                  op != mifd_pkg::MIFD_OP_RET;
      st_next.phase = st_reg.phase + 2'h1;                                // [RQ8]
      st_next.rd_en = 1'b0;
      st_next.wr_en = 1'b0;
      st_next.rearm = 1'b0;
      // phase 0: read the file register, even for pure writes
      if (st_reg.phase == 2'h0 && uses_file) begin
         st_next.rd_en = 1'b1;                                            // [RQ11] [RQ12]
         st_next.rearm = (faddr == mifd_pkg::IO_PORT2_ADDR);              // [RQ13]
      end
      if (st_reg.phase == 2'h1 && st_reg.rd_en) begin
         st_next.opnd = file_rd_data;                                     // [RQ11]
      end
      // phase 2: modify and store
      if (st_reg.phase == 2'h2 && !st_reg.flush) begin
         unique case (op)
            mifd_pkg::MIFD_OP_MOVWF: begin res = st_reg.acc; to_file = 1'b1; end  // [RQ15]
            mifd_pkg::MIFD_OP_CLRF:  begin res = 8'h00; to_file = 1'b1; end       // [RQ12]
            mifd_pkg::MIFD_OP_CLRW:  st_next.acc = 8'h00;
            mifd_pkg::MIFD_OP_SUB:   begin sum = {1'b0, st_reg.opnd} - {1'b0, st_reg.acc}; res = sum[7:0]; end
            mifd_pkg::MIFD_OP_DEC:   res = st_reg.opnd - 8'h01;
            mifd_pkg::MIFD_OP_IOR:   res = st_reg.opnd | st_reg.acc;
            mifd_pkg::MIFD_OP_AND:   res = st_reg.opnd & st_reg.acc;
            mifd_pkg::MIFD_OP_XOR:   res = st_reg.opnd ^ st_reg.acc;
            mifd_pkg::MIFD_OP_ADD:   begin sum = {1'b0, st_reg.opnd} + {1'b0, st_reg.acc}; res = sum[7:0]; end
            mifd_pkg::MIFD_OP_MOV:   res = st_reg.opnd;
            mifd_pkg::MIFD_OP_COM:   res = ~st_reg.opnd;
            mifd_pkg::MIFD_OP_INC:   res = st_reg.opnd + 8'h01;
            mifd_pkg::MIFD_OP_DECSZ: begin res = st_reg.opnd - 8'h01; skip = (res == 8'h00); end  // [RQ9]
            mifd_pkg::MIFD_OP_INCSZ: begin res = st_reg.opnd + 8'h01; skip = (res == 8'h00); end  // [RQ9]
            mifd_pkg::MIFD_OP_RRF:   res = {st_reg.opnd[0], st_reg.opnd[7:1]};  // bit 0 wraps into bit 7, no carry
            mifd_pkg::MIFD_OP_RLF:   res = {st_reg.opnd[6:0], st_reg.opnd[7]};
            mifd_pkg::MIFD_OP_SWAP:  res = {st_reg.opnd[3:0], st_reg.opnd[7:4]};
            mifd_pkg::MIFD_OP_BCLR:  begin res = st_reg.opnd & ~mask; to_file = 1'b1; end   // [RQ6]
            mifd_pkg::MIFD_OP_BSET:  begin res = st_reg.opnd | mask; to_file = 1'b1; end    // [RQ6]
            mifd_pkg::MIFD_OP_BTSC:  skip = ((st_reg.opnd & mask) == 8'h00);               // [RQ9]
            mifd_pkg::MIFD_OP_BTSS:  skip = ((st_reg.opnd & mask) != 8'h00);               // [RQ9]
            mifd_pkg::MIFD_OP_LMOV:  st_next.acc = lit8;                                   // [RQ7] [RQ15]
            mifd_pkg::MIFD_OP_LIOR:  st_next.acc = st_reg.acc | lit8;
            mifd_pkg::MIFD_OP_LAND:  st_next.acc = st_reg.acc & lit8;
            mifd_pkg::MIFD_OP_LXOR:  st_next.acc = st_reg.acc ^ lit8;
            mifd_pkg::MIFD_OP_LSUB:  st_next.acc = lit8 - st_reg.acc;
            mifd_pkg::MIFD_OP_LADD:  st_next.acc = lit8 + st_reg.acc;
            mifd_pkg::MIFD_OP_LRET:  st_next.acc = lit8;
            default:                 res = st_reg.opnd;                                    // [RQ17]
         endcase
         // byte ops steer by the target bit
         if (cls == mifd_pkg::MIFD_CLS_BYTE && op != mifd_pkg::MIFD_OP_MOVWF &&
             op != mifd_pkg::MIFD_OP_CLRF && op != mifd_pkg::MIFD_OP_CLRW &&
             op != mifd_pkg::MIFD_OP_RET && op != mifd_pkg::MIFD_OP_IDLE) begin
            if (dest_file) begin
               to_file = 1'b1;                                            // [RQ3]
            end else begin
               st_next.acc = res;                                         // [RQ3] [RQ15]
            end
         end
         st_next.wr_en = to_file;                                         // [RQ11]
         st_next.wr_data = res;
         // program counter changes and skips
         unique case (op)
            mifd_pkg::MIFD_OP_CALL: begin
               st_next.pc = {st_reg.pc[12:11], lit11};                    // [RQ7]
               st_next.sp = st_reg.sp + 4'h1;
               st_next.flush = 1'b1;                                      // [RQ9] [RQ16]
            end
            mifd_pkg::MIFD_OP_JUMP: begin
               st_next.pc = {st_reg.pc[12:11], lit11};                    // [RQ7]
               st_next.flush = 1'b1;                                      // [RQ16]
            end
            mifd_pkg::MIFD_OP_RET, mifd_pkg::MIFD_OP_LRET: begin
               st_next.pc = stack_reg[4'(st_reg.sp - 4'h1) % STACK_DEP];
               st_next.sp = st_reg.sp - 4'h1;
               st_next.flush = 1'b1;                                      // [RQ16]
            end
            default: begin
               st_next.flush = skip;                                      // [RQ9] [RQ16]
               st_next.pc = st_reg.pc + (skip ? 13'h0002 : 13'h0001);
            end
         endcase
      end else if (st_reg.phase == 2'h2) begin
         // idle second cycle: pc already names the word to fetch, so
         // stepping it here would lose the jump target or skip landing
         st_next.flush = 1'b0;                                            // [RQ9]
      end
      // phase 3: load next word; after a change the idle word INSTR_RST is loaded instead
      if (st_reg.phase == 2'h3) begin
         st_next.instr = st_next.flush ? mifd_pkg::INSTR_RST : instr_word;  // [RQ16]
         st_next.idle  = st_reg.flush;                                    // [RQ9] [RQ16]
      end
      if (rst) begin
         st_next = '0;
         st_next.phase = mifd_pkg::PHASE_RST;
         st_next.acc   = mifd_pkg::ACC_RST;
         st_next.pc    = mifd_pkg::PC_RST;
         st_next.instr = mifd_pkg::INSTR_RST;
         // first cycle is a dummy, so address zero is fetched before use
         st_next.flush = 1'b1;
         st_next.idle  = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clock) begin
      st_reg <= st_next;
   end

   ////////////////////////////////////////////////////////////////////////
   // return stack, one generate entry per slot; no reset needed
   for (genvar i = 0; i < STACK_DEP; i++) begin : g_stack
      always_ff @(posedge clock) begin
         if (!rst && st_reg.phase == 2'h2 && !st_reg.flush && op == mifd_pkg::MIFD_OP_CALL &&
             (st_reg.sp % STACK_DEP) == i) begin
            stack_reg[i] <= st_reg.pc + 13'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign program_counter   = st_reg.pc;
   assign fetch_en          = (st_reg.phase == 2'h3);
   assign file_rd_en        = st_reg.rd_en;
   assign file_wr_en        = st_reg.wr_en;
   assign file_addr         = faddr;
   assign file_wr_data      = st_reg.wr_data;
   assign port_change_rearm = st_reg.rearm;
   assign accumulator       = st_reg.acc;
   assign phase             = st_reg.phase;
   assign idle_cycle        = st_reg.idle;

endmodule

/* pkg/mifd_pkg.sv */
// package for the instruction format decoder: field layout, opcode
// classes, operation codes, phase counts and reset values.
// assumes a single 20 MHz core clock and a synchronous active-high reset.
package mifd_pkg;

   // instruction word geometry
   localparam int INSTR_W      = 14;   // one instruction word
   localparam int DATA_W       = 8;    // file register and accumulator width
   localparam int FADDR_W      = 7;    // register selector width
   localparam int BITSEL_W     = 3;    // selected position width
   localparam int JUMP_W       = 11;   // long constant width

   // field positions
   localparam int CLASS_HI     = 13;   // class field top bit
   localparam int CLASS_LO     = 12;   // class field low bit
   localparam int DEST_POS     = 7;    // result target bit
   localparam int BITSEL_LO    = 7;    // selected position low bit
   localparam int JUMP_SEL_POS = 11;   // call/jump select bit

   // register selector range
   localparam logic [6:0] FADDR_MIN = 7'h00;
   localparam logic [6:0] FADDR_MAX = 7'h7f;

   // address of the second i/o port inside the bank
   localparam logic [6:0] IO_PORT2_ADDR = 7'h06;

   // four oscillator periods per instruction cycle
   localparam int PHASES       = 4;
   localparam logic [1:0] PHASE_RST = 2'h0;

   // reset values
   localparam logic [7:0]  ACC_RST  = 8'h00;
   localparam logic [12:0] PC_RST   = 13'h0000;
   localparam logic [13:0] INSTR_RST = 14'h0000;  // decodes as an idle cycle

   // instruction classes
   typedef enum logic [1:0] {
      MIFD_CLS_BYTE,
      MIFD_CLS_BIT,
      MIFD_CLS_LIT
   } mifd_class_t;

   // decoded operations
   typedef enum logic [4:0] {
      MIFD_OP_IDLE, MIFD_OP_MOVWF, MIFD_OP_CLRW, MIFD_OP_CLRF, MIFD_OP_SUB,
      MIFD_OP_DEC,  MIFD_OP_IOR,   MIFD_OP_AND,  MIFD_OP_XOR,  MIFD_OP_ADD,
      MIFD_OP_MOV,  MIFD_OP_COM,   MIFD_OP_INC,  MIFD_OP_DECSZ, MIFD_OP_RRF,
      MIFD_OP_RLF,  MIFD_OP_SWAP,  MIFD_OP_INCSZ, MIFD_OP_BCLR, MIFD_OP_BSET,
      MIFD_OP_BTSC, MIFD_OP_BTSS,  MIFD_OP_CALL, MIFD_OP_JUMP, MIFD_OP_LMOV,
      MIFD_OP_LRET, MIFD_OP_LIOR,  MIFD_OP_LAND, MIFD_OP_LXOR, MIFD_OP_LSUB,
      MIFD_OP_LADD, MIFD_OP_RET
   } mifd_op_t;

endpackage

/* rtl/mifd_field_split.sv */
// field splitter: breaks one instruction word into class, operation and
// operand fields, combinationally.
// assumes the word is stable for the whole instruction cycle.
`timescale 1ns/1ns
module mifd_field_split (
   input  wire logic [13:0]          instr,
   output mifd_pkg::mifd_class_t     instr_class,
   output mifd_pkg::mifd_op_t        op,
   output logic                      dest_file,
   output logic [6:0]                faddr,
   output logic [2:0]                bit_sel,
   output logic [7:0]                lit8,
   output logic [10:0]               lit11
);

   ////////////////////////////////////////////////////////////////////////
   // operand fields; unused ones are simply ignored downstream
   assign dest_file = instr[mifd_pkg::DEST_POS];                         // [RQ3]
   assign faddr     = instr[6:0];                                         // [RQ5]
   assign bit_sel   = instr[9:7];                                         // [RQ6]
   assign lit8      = instr[7:0];                                         // [RQ7]
   assign lit11     = instr[10:0];                                        // [RQ7]

   ////////////////////////////////////////////////////////////////////////
   // class and operation; x bits are never looked at
   always_comb begin
      op = mifd_pkg::MIFD_OP_IDLE;                                        // [RQ17]
      unique case (instr[13:12])
         2'h0: begin
            instr_class = mifd_pkg::MIFD_CLS_BYTE;                         // [RQ2]
            unique case (instr[11:8])
               4'h0: begin
                  if (instr[7]) begin
                     op = mifd_pkg::MIFD_OP_MOVWF;
                  end else if (instr[6:0] == 7'h08 || instr[6:0] == 7'h09) begin
                     op = mifd_pkg::MIFD_OP_RET;                          // both returns
                  end else begin
                     op = mifd_pkg::MIFD_OP_IDLE;                         // [RQ10] [RQ17]
                  end
               end
               4'h1: op = instr[7] ? mifd_pkg::MIFD_OP_CLRF : mifd_pkg::MIFD_OP_CLRW; // [RQ10]
               4'h2: op = mifd_pkg::MIFD_OP_SUB;
               4'h3: op = mifd_pkg::MIFD_OP_DEC;
               4'h4: op = mifd_pkg::MIFD_OP_IOR;
               4'h5: op = mifd_pkg::MIFD_OP_AND;
               4'h6: op = mifd_pkg::MIFD_OP_XOR;
               4'h7: op = mifd_pkg::MIFD_OP_ADD;
               4'h8: op = mifd_pkg::MIFD_OP_MOV;
               4'h9: op = mifd_pkg::MIFD_OP_COM;
               4'ha: op = mifd_pkg::MIFD_OP_INC;
               4'hb: op = mifd_pkg::MIFD_OP_DECSZ;
               4'hc: op = mifd_pkg::MIFD_OP_RRF;
               4'hd: op = mifd_pkg::MIFD_OP_RLF;
               4'he: op = mifd_pkg::MIFD_OP_SWAP;
               4'hf: op = mifd_pkg::MIFD_OP_INCSZ;
            endcase
         end
         2'h1: begin
            instr_class = mifd_pkg::MIFD_CLS_BIT;                          // [RQ2]
            unique case (instr[11:10])
               2'h0: op = mifd_pkg::MIFD_OP_BCLR;
               2'h1: op = mifd_pkg::MIFD_OP_BSET;
               2'h2: op = mifd_pkg::MIFD_OP_BTSC;
               2'h3: op = mifd_pkg::MIFD_OP_BTSS;
            endcase
         end
         2'h2: begin
            instr_class = mifd_pkg::MIFD_CLS_LIT;                          // [RQ2]
            op = instr[mifd_pkg::JUMP_SEL_POS] ? mifd_pkg::MIFD_OP_JUMP : mifd_pkg::MIFD_OP_CALL;
         end
         2'h3: begin
            instr_class = mifd_pkg::MIFD_CLS_LIT;                          // [RQ2]
            unique casez (instr[11:8])
               4'b00??: op = mifd_pkg::MIFD_OP_LMOV;                       // [RQ10]
               4'b01??: op = mifd_pkg::MIFD_OP_LRET;                       // [RQ10]
               4'b1000: op = mifd_pkg::MIFD_OP_LIOR;
               4'b1001: op = mifd_pkg::MIFD_OP_LAND;
               4'b1010: op = mifd_pkg::MIFD_OP_LXOR;
               4'b1011: op = mifd_pkg::MIFD_OP_IDLE;                       // [RQ17]
               4'b110?: op = mifd_pkg::MIFD_OP_LSUB;                       // [RQ10]
               4'b111?: op = mifd_pkg::MIFD_OP_LADD;                       // [RQ10]
            endcase
         end
      endcase
   end

endmodule

/* testbench/mifd_core_properties.sv */
// checker for the instruction sequencer: phase order, strobe timing, idle cycles.
// assumes it is bound to mifd_core and sees only its ports.
`timescale 1ns/1ns
module mifd_core_properties #(
   parameter int PC_W      = 13,   // program counter width
   parameter int STACK_DEP = 8     // return stack depth
) (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic [12:0] program_counter,
   input wire logic        fetch_en,
   input wire logic        file_rd_en,
   input wire logic        file_wr_en,
   input wire logic [6:0]  file_addr,
   input wire logic        port_change_rearm,
   input wire logic [7:0]  accumulator,
   input wire logic [1:0]  phase,
   input wire logic        idle_cycle
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   // skip the release edge: phase was held at zero through reset
   a_phase_steps_round: assert property (!$past(rst) |-> phase == $past(phase) + 2'h1)
      else $error("phase did not advance by one");
   a_fetch_last_phase: assert property (fetch_en == (phase == 2'h3))
      else $error("fetch strobe outside last phase");
   a_read_in_p1: assert property (file_rd_en |-> phase == 2'h1)
      else $error("file read outside phase one");
   // every store must be preceded by a read of the same register
   a_store_after_read: assert property (file_wr_en |-> phase == 2'h3 && $past(file_rd_en, 2)
      && $past(file_addr, 2) == file_addr)
      else $error("file store without matching read");
   a_rearm_port_read: assert property (port_change_rearm == (file_rd_en && file_addr == mifd_pkg::IO_PORT2_ADDR))
      else $error("port rearm does not match port read");
   a_idle_whole_cycle: assert property ($rose(idle_cycle) |-> phase == 2'h0 ##0 idle_cycle [*4])
      else $error("idle cycle not four clocks from phase zero");
   a_idle_no_strobe: assert property (idle_cycle |-> !file_rd_en && !file_wr_en)
      else $error("file access during idle cycle");
   a_acc_at_end: assert property ($changed(accumulator) |-> phase == 2'h3)
      else $error("accumulator changed mid cycle");
   a_pc_at_end: assert property ($changed(program_counter) |-> phase == 2'h3)
      else $error("program counter changed mid cycle");
   cover property ($rose(idle_cycle));
endmodule

/* testbench/mifd_prog_file_model.sv */
// program memory and register file facing the sequencer.
// assumes the bench loads rom and regs before reset is released.
`timescale 1ns/1ns
module mifd_prog_file_model (
   input  wire logic        clock,
   input  wire logic [12:0] program_counter,
   output logic [13:0]      instr_word,
   input  wire logic        file_rd_en,
   input  wire logic        file_wr_en,
   input  wire logic [6:0]  file_addr,
   input  wire logic [7:0]  file_wr_data,
   output logic [7:0]       file_rd_data
);
   logic [13:0] rom [0:15];        // small program, pc wraps on 16 words
   logic [7:0]  regs [0:127];      // whole bank, selector 0x00..0x7f
   logic [7:0]  junk = 8'h00;      // toggling filler while not read
   ////////////////////////////////////////////////////////////////////////
   // fetch path: word for the current address, half a cycle later
   initial instr_word = 14'h0000;
   always @(negedge clock) begin
      instr_word <= rom[program_counter[3:0]];
      junk       <= ~junk;
   end
   // read data only valid with the strobe, so a late sample sees junk
   assign file_rd_data = file_rd_en ? regs[file_addr] : junk;
   // store on the strobe edge
   always @(posedge clock) begin
      if (file_wr_en) begin
         regs[file_addr] <= file_wr_data;
      end
   end
endmodule

/* testbench/mifd_core_test.sv */
// self-checking bench: runs a short program and compares stores, reads
// and the accumulator with a queue model.
// assumes mifd_prog_file_model as fetch path and register file.
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
   $display("Error at %0t: got %h expected %h", $time, g, e); end end
module mifd_core_test;
   logic        clock, rst, fetch_en, file_rd_en, file_wr_en, port_change_rearm, idle_cycle;
   logic [13:0] instr_word;
   logic [12:0] program_counter;
   logic [6:0]  file_addr, exp_a;   // exp_a: popped read address
   logic [14:0] exp_w;              // popped store entry
   logic [7:0]  file_rd_data, file_wr_data, accumulator, lit, r21, acc_m;
   logic [1:0]  phase;
   logic [14:0] wr_q [$];           // expected {address, data} of stores
   logic [6:0]  rd_q [$];           // expected read addresses
   logic [13:0] prog [0:15];
   int checks = 0, bad_count = 0, seed = 43, idles = 0, rearms = 0;
   logic        idle_prev = 1'b0, in_win = 1'b0;
   mifd_core DUT (.clock(clock), .rst(rst), .instr_word(instr_word), .program_counter(program_counter),
      .fetch_en(fetch_en), .file_rd_en(file_rd_en), .file_wr_en(file_wr_en), .file_addr(file_addr),
      .file_rd_data(file_rd_data), .file_wr_data(file_wr_data), .port_change_rearm(port_change_rearm),
      .accumulator(accumulator), .phase(phase), .idle_cycle(idle_cycle));
   mifd_prog_file_model partner (.clock(clock), .program_counter(program_counter), .instr_word(instr_word),
      .file_rd_en(file_rd_en), .file_wr_en(file_wr_en), .file_addr(file_addr),
      .file_wr_data(file_wr_data), .file_rd_data(file_rd_data));
   task summarize();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // watchdog: the program settles in well under 4000 cycles
   initial begin
      #(50 * 4000);
      bad_count++;
      summarize();
   end
   // monitors at the falling edge, where strobes have settled
   always @(negedge clock) begin
      if (file_rd_en) begin
         if (rd_q.size() > 0) begin
            exp_a = rd_q.pop_front();
            `CHK(file_addr, exp_a)
         end else `CHK(file_rd_en, 1'b0)
      end
      if (file_wr_en) begin
         if (wr_q.size() > 0) begin
            exp_w = wr_q.pop_front();
            `CHK({file_addr, file_wr_data}, exp_w)
         end else `CHK(file_wr_en, 1'b0)
         in_win = (file_addr == 7'h21);
      end
      if (port_change_rearm) rearms++;
      if (in_win && idle_cycle && !idle_prev) idles++;
      idle_prev = idle_cycle;
   end
   // main sequence: build program, model it, run, compare
   initial begin
      rst = 1'b1;
      lit = 8'($random(seed));
      for (int i = 0; i < 128; i++) partner.regs[i] = 8'($random(seed));
      r21  = partner.regs[33];
      // tools set target bit to one and don't-care bits to zero
      prog = '{14'h3000 | {6'h00, lit}, // literal to acc
               14'h00a0,                // acc to 0x20
               14'h0aa0,                // increment 0x20 back to file
               14'h0186,                // clear second_io_port: still read
               14'h0720,                // add 0x20 into acc
               14'h15a1,                // set bit 3 of 0x21
               14'h1da1,                // test bit 3 set: skip
               14'h30ff,                // skipped
               14'h280a,                // jump to 10
               14'h30ee,                // jumped over, never fetched
               14'h3a0f,                // xor literal
               14'h00a2,                // acc to 0x22
               14'h3b00,                // undefined: idle
               14'h3311,                // literal with don't-care bits set
               14'h280e,                // park
               14'h0000};
      for (int i = 0; i < 16; i++) partner.rom[i] = prog[i];
      acc_m = lit + (lit + 8'h01);
      wr_q = '{{7'h20, lit}, {7'h20, lit + 8'h01}, {7'h06, 8'h00},
               {7'h21, r21 | 8'h08}, {7'h22, acc_m ^ 8'h0f}};
      rd_q = '{7'h20, 7'h20, 7'h06, 7'h20, 7'h21, 7'h21, 7'h22};
      repeat (10) @(negedge clock);
      rst = 1'b0;
      repeat (300) @(negedge clock);
      `CHK(accumulator, 8'h11)
      `CHK(program_counter, 13'h000e)
      `CHK(wr_q.size(), 0)
      `CHK(rd_q.size(), 0)
      `CHK(rearms, 1)
      `CHK(idles, 2)
      summarize();
   end
endmodule
bind mifd_core mifd_core_properties #(.PC_W(PC_W), .STACK_DEP(STACK_DEP)) u_props (.clock(clock),
   .rst(rst), .program_counter(program_counter), .fetch_en(fetch_en), .file_rd_en(file_rd_en),
   .file_wr_en(file_wr_en), .file_addr(file_addr), .port_change_rearm(port_change_rearm),
   .accumulator(accumulator), .phase(phase), .idle_cycle(idle_cycle));
